// [design/diag_params.svh]
// offsets, field positions, reset values, thresholds and timing of the diagnostic flag block
`ifndef DIAG_PARAMS_SVH
`define DIAG_PARAMS_SVH

// ==========================================================================
// register offsets
`define OFS_STATUS_CONTROL   8'h6e
`define OFS_ALARM_FLAGS_HI   8'h70
`define OFS_ALARM_FLAGS_LO   8'h71
`define OFS_WARNING_FLAGS_HI 8'h74
`define OFS_WARNING_FLAGS_LO 8'h75

// ==========================================================================
// status_control field positions
`define SC_TXDIS_STATE_BIT   7
`define SC_SOFT_TXDIS_BIT    6
`define SC_LOS_STATE_BIT     1
`define SC_NOT_READY_BIT     0

// ==========================================================================
// reset and idle values
`define SOFT_TXDIS_RESET     1'b0
`define FLAGS_RESET          8'h00
`define RESERVED_READ        8'h00
`define RDATA_RESET          8'h00

// ==========================================================================
// temperature: signed, 1/256 degree per lsb
`define TEMP_LSB_PER_C       256
`define TEMP_HI_ALARM_C      85
`define TEMP_LO_ALARM_C      (-40)
`define TEMP_HI_WARN_C       80
`define TEMP_LO_WARN_C       (-35)
`define TEMP_RAW(c)          16'((c) * `TEMP_LSB_PER_C)

// supply: 100 uV per lsb, so ten counts per millivolt
`define VCC_CNT_PER_MV       10
`define VCC_HI_ALARM_MV      3600
`define VCC_LO_ALARM_MV      3000
`define VCC_HI_WARN_MV       3500
`define VCC_LO_WARN_MV       3100
`define VCC_RAW(mv)          16'((mv) * `VCC_CNT_PER_MV)

// led bias: 2 uA per lsb (120, 10, 110, 15 mA)
`define BIAS_HI_ALARM        16'hea60
`define BIAS_LO_ALARM        16'h1388
`define BIAS_HI_WARN         16'hd6d8
`define BIAS_LO_WARN         16'h1d4c

// optical power: 0.1 uW per lsb (tx -11/-23/-12/-22 dBm, rx -11/-33/-12/-32 dBm)
`define TXPWR_HI_ALARM       16'h031a
`define TXPWR_LO_ALARM       16'h0032
`define TXPWR_HI_WARN        16'h0277
`define TXPWR_LO_WARN        16'h003f
`define RXPWR_HI_ALARM       16'h031a
`define RXPWR_LO_ALARM       16'h0005
`define RXPWR_HI_WARN        16'h0277
`define RXPWR_LO_WARN        16'h0006

// ==========================================================================
// timing
`define CLK_PERIOD_NS        5
`define REFRESH_PERIOD_NS    1000
`define REFRESH_CYCLES       ((`REFRESH_PERIOD_NS) / (`CLK_PERIOD_NS))
`define REFRESH_CNT_W        8

`endif

// [design/diag_pkg.sv]
// types shared by the diagnostic flag block
`include "diag_params.svh"
package diag_pkg;

  // ==========================================================================
  // readiness of the monitored values
  typedef enum logic [1:0] {
    RDY_OFF,
    RDY_SETTLE,
    RDY_ON
  } ready_e;

  // ==========================================================================
  // state of the refresh divider
  typedef struct packed {
    logic [`REFRESH_CNT_W-1:0] cnt;
    logic                      tick;
  } div_state_s;

  // ==========================================================================
  // state of the top block
  typedef struct packed {
    ready_e     rdy;
    logic       soft_txdis;
    logic       tx_disable;
    logic       rx_lost;
    logic       not_ready;
    logic [7:0] alarm_hi;
    logic [7:0] alarm_lo;
    logic [7:0] warn_hi;
    logic [7:0] warn_lo;
    logic [7:0] rdata;
    logic       rvalid;
  } diag_state_s;

endpackage

// [design/refresh_divider.sv]
// one-cycle refresh enable pulse from a free running counter
`timescale 1ns/1ps
`include "diag_params.svh"
module refresh_divider
  import diag_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // enable pulse
  output wire logic tick
);

  div_state_s s_q;
  div_state_s s_d;

  localparam logic [`REFRESH_CNT_W-1:0] LAST = `REFRESH_CNT_W'(`REFRESH_CYCLES - 1);

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (s_q.cnt == LAST) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + `REFRESH_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule

// [design/threshold_compare.sv]
// four-way comparison of one monitored value against its alarm and warning limits
`timescale 1ns/1ps
module threshold_compare #(
  parameter bit          IS_SIGNED = 1'b0,
  parameter logic [15:0] HI_ALARM  = 16'hffff,
  parameter logic [15:0] LO_ALARM  = 16'h0000,
  parameter logic [15:0] HI_WARN   = 16'hffff,
  parameter logic [15:0] LO_WARN   = 16'h0000
) (
  // live value
  input  wire logic [15:0] value,
  // comparison results
  output wire logic        hi_alarm,
  output wire logic        lo_alarm,
  output wire logic        hi_warn,
  output wire logic        lo_warn
);

  // flipping the sign bit turns a signed compare into an unsigned one
  logic [15:0] v;
  logic [15:0] ha;
  logic [15:0] la;
  logic [15:0] hw;
  logic [15:0] lw;
  logic [15:0] bias;

  assign bias     = IS_SIGNED ? 16'h8000 : 16'h0000;
  assign v        = value ^ bias;
  assign ha       = HI_ALARM ^ bias;
  assign la       = LO_ALARM ^ bias;
  assign hw       = HI_WARN ^ bias;
  assign lw       = LO_WARN ^ bias;
  assign hi_alarm = v > ha;
  assign lo_alarm = v < la;
  assign hi_warn  = v > hw;
  assign lo_warn  = v < lw;

endmodule

// [design/diag_status_alarm_flags.sv]
// status/control byte and alarm and warning flag bytes of the diagnostic monitor
//
// Summary of operation
// R01: status bit mirrors signal-lost pin level
// R02: not-ready bit low once values valid
// R03: host reads and writes soft transmit disable
// R04: read-only bit shows transmit disable state
// R05: alarm byte one: temperature high/low flags
// R06: alarm byte one: supply voltage high/low flags
// R07: alarm byte one: led bias high/low flags
// R08: alarm byte one: tx power high/low flags
// R09: alarm byte two: rx power, rest reserved
// R10: warning byte one: temperature high/low flags
// R11: warning byte one: supply high/low flags
// R12: warning byte one: led bias high/low flags
// R13: warning byte one: tx power high/low flags
// R14: warning byte two: rx power, rest reserved
// R15: fixed factory temperature and supply limits
// R16: temperature is signed, 1/256 degree lsb
// R17: flags refreshed by repeated live comparisons
// R18: host reads bytes, ignores reserved bits
`timescale 1ns/1ps
`include "diag_params.svh"
module diag_status_alarm_flags
  import diag_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // byte register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output wire logic [7:0]  reg_rdata_q,
  output wire logic        reg_rvalid_q,
  // pins
  input  wire logic        rx_signal_lost,
  input  wire logic        tx_disable_pin,
  output wire logic        tx_disable_q,
  // monitored values
  input  wire logic        mon_valid,
  input  wire logic [15:0] mon_temp,
  input  wire logic [15:0] mon_vcc,
  input  wire logic [15:0] mon_bias,
  input  wire logic [15:0] mon_txpwr,
  input  wire logic [15:0] mon_rxpwr,
  // readiness
  output wire logic        data_not_ready_q
);

  // ==========================================================================
  // refresh pacing
  logic tick;

  refresh_divider u_div (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tick    (tick)
  );

  // ==========================================================================
  // comparators, one per monitored quantity
  logic t_ha;
  logic t_la;
  logic t_hw;
  logic t_lw;
  logic v_ha;
  logic v_la;
  logic v_hw;
  logic v_lw;
  logic b_ha;
  logic b_la;
  logic b_hw;
  logic b_lw;
  logic tp_ha;
  logic tp_la;
  logic tp_hw;
  logic tp_lw;
  logic rp_ha;
  logic rp_la;
  logic rp_hw;
  logic rp_lw;

  // temperature compares as signed two's complement
  threshold_compare #(
    .IS_SIGNED (1'b1),                                 // [R16]
    .HI_ALARM  (`TEMP_RAW(`TEMP_HI_ALARM_C)),          // [R15]
    .LO_ALARM  (`TEMP_RAW(`TEMP_LO_ALARM_C)),          // [R15]
    .HI_WARN   (`TEMP_RAW(`TEMP_HI_WARN_C)),           // [R15]
    .LO_WARN   (`TEMP_RAW(`TEMP_LO_WARN_C))            // [R15]
  ) u_cmp_temp (
    .value    (mon_temp),
    .hi_alarm (t_ha),
    .lo_alarm (t_la),
    .hi_warn  (t_hw),
    .lo_warn  (t_lw)
  );

  threshold_compare #(
    .IS_SIGNED (1'b0),
    .HI_ALARM  (`VCC_RAW(`VCC_HI_ALARM_MV)),           // [R15]
    .LO_ALARM  (`VCC_RAW(`VCC_LO_ALARM_MV)),           // [R15]
    .HI_WARN   (`VCC_RAW(`VCC_HI_WARN_MV)),
    .LO_WARN   (`VCC_RAW(`VCC_LO_WARN_MV))
  ) u_cmp_vcc (
    .value    (mon_vcc),
    .hi_alarm (v_ha),
    .lo_alarm (v_la),
    .hi_warn  (v_hw),
    .lo_warn  (v_lw)
  );

  threshold_compare #(
    .IS_SIGNED (1'b0),
    .HI_ALARM  (`BIAS_HI_ALARM),
    .LO_ALARM  (`BIAS_LO_ALARM),
    .HI_WARN   (`BIAS_HI_WARN),
    .LO_WARN   (`BIAS_LO_WARN)
  ) u_cmp_bias (
    .value    (mon_bias),
    .hi_alarm (b_ha),
    .lo_alarm (b_la),
    .hi_warn  (b_hw),
    .lo_warn  (b_lw)
  );

  threshold_compare #(
    .IS_SIGNED (1'b0),
    .HI_ALARM  (`TXPWR_HI_ALARM),
    .LO_ALARM  (`TXPWR_LO_ALARM),
    .HI_WARN   (`TXPWR_HI_WARN),
    .LO_WARN   (`TXPWR_LO_WARN)
  ) u_cmp_txpwr (
    .value    (mon_txpwr),
    .hi_alarm (tp_ha),
    .lo_alarm (tp_la),
    .hi_warn  (tp_hw),
    .lo_warn  (tp_lw)
  );

  threshold_compare #(
    .IS_SIGNED (1'b0),
    .HI_ALARM  (`RXPWR_HI_ALARM),
    .LO_ALARM  (`RXPWR_LO_ALARM),
    .HI_WARN   (`RXPWR_HI_WARN),
    .LO_WARN   (`RXPWR_LO_WARN)
  ) u_cmp_rxpwr (
    .value    (mon_rxpwr),
    .hi_alarm (rp_ha),
    .lo_alarm (rp_la),
    .hi_warn  (rp_hw),
    .lo_warn  (rp_lw)
  );

  // ==========================================================================
  // flag bytes assembled from the comparators
  logic [7:0] alarm_hi_live;
  logic [7:0] alarm_lo_live;
  logic [7:0] warn_hi_live;
  logic [7:0] warn_lo_live;

  assign alarm_hi_live = {t_ha, t_la,                  // [R05]
                          v_ha, v_la,                  // [R06]
                          b_ha, b_la,                  // [R07]
                          tp_ha, tp_la};               // [R08]
  assign alarm_lo_live = {rp_ha, rp_la, 6'b00_0000};   // [R09]
  assign warn_hi_live  = {t_hw, t_lw,                  // [R10]
                          v_hw, v_lw,                  // [R11]
                          b_hw, b_lw,                  // [R12]
                          tp_hw, tp_lw};               // [R13]
  assign warn_lo_live  = {rp_hw, rp_lw, 6'b00_0000};   // [R14]

  // ==========================================================================
  // state
  diag_state_s s_q;
  diag_state_s s_d;

  logic [7:0] status_byte;

  // status byte as seen by the host; reserved bits read zero
  always_comb begin
    status_byte                        = `RESERVED_READ;
    status_byte[`SC_TXDIS_STATE_BIT]   = s_q.tx_disable;   // [R04]
    status_byte[`SC_SOFT_TXDIS_BIT]    = s_q.soft_txdis;   // [R03]
    status_byte[`SC_LOS_STATE_BIT]     = s_q.rx_lost;      // [R01]
    status_byte[`SC_NOT_READY_BIT]     = s_q.not_ready;    // [R02]
  end

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;

    // pin level captured every cycle, so the bit follows the pin
    s_d.rx_lost = rx_signal_lost;                          // [R01]

    // only the soft disable bit is writable; other bits and bytes ignore writes
    if (reg_wr && (reg_addr == `OFS_STATUS_CONTROL)) begin
      s_d.soft_txdis = reg_wdata[`SC_SOFT_TXDIS_BIT];      // [R03]
    end

    // effective disable: either the pin or the soft bit turns the transmitter off
    s_d.tx_disable = s_d.soft_txdis | tx_disable_pin;      // [R03] [R04]

    // readiness and flag refresh
    case (s_q.rdy)
      RDY_OFF: begin
        s_d.alarm_hi = `FLAGS_RESET;
        s_d.alarm_lo = `FLAGS_RESET;
        s_d.warn_hi  = `FLAGS_RESET;
        s_d.warn_lo  = `FLAGS_RESET;
        if (mon_valid) begin
          s_d.rdy = RDY_SETTLE;
        end
      end
      RDY_SETTLE: begin
        // wait for one full comparison pass before claiming ready
        if (!mon_valid) begin
          s_d.rdy = RDY_OFF;
        end else if (tick) begin
          s_d.alarm_hi = alarm_hi_live;                    // [R17]
          s_d.alarm_lo = alarm_lo_live;                    // [R17]
          s_d.warn_hi  = warn_hi_live;                     // [R17]
          s_d.warn_lo  = warn_lo_live;                     // [R17]
          s_d.rdy      = RDY_ON;
        end
      end
      RDY_ON: begin
        if (!mon_valid) begin
          s_d.rdy      = RDY_OFF;
          s_d.alarm_hi = `FLAGS_RESET;
          s_d.alarm_lo = `FLAGS_RESET;
          s_d.warn_hi  = `FLAGS_RESET;
          s_d.warn_lo  = `FLAGS_RESET;
        end else if (tick) begin
          // flags follow live conditions, they are not sticky
          s_d.alarm_hi = alarm_hi_live;                    // [R17]
          s_d.alarm_lo = alarm_lo_live;                    // [R17]
          s_d.warn_hi  = warn_hi_live;                     // [R17]
          s_d.warn_lo  = warn_lo_live;                     // [R17]
        end
      end
      default: begin
        s_d.rdy = RDY_OFF;
      end
    endcase

    s_d.not_ready = (s_d.rdy != RDY_ON);                   // [R02]

    // read answer one cycle after the strobe; unmapped bytes read zero
    if (reg_rd) begin
      s_d.rvalid = 1'b1;
      case (reg_addr)
        `OFS_STATUS_CONTROL:   s_d.rdata = status_byte;
        `OFS_ALARM_FLAGS_HI:   s_d.rdata = s_q.alarm_hi;
        `OFS_ALARM_FLAGS_LO:   s_d.rdata = s_q.alarm_lo;   // [R09]
        `OFS_WARNING_FLAGS_HI: s_d.rdata = s_q.warn_hi;
        `OFS_WARNING_FLAGS_LO: s_d.rdata = s_q.warn_lo;    // [R14]
        default:               s_d.rdata = `RESERVED_READ;
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q            <= '0;
      s_q.rdy        <= RDY_OFF;
      s_q.soft_txdis <= `SOFT_TXDIS_RESET;
      s_q.tx_disable <= `SOFT_TXDIS_RESET;
      s_q.not_ready  <= 1'b1;
      s_q.alarm_hi   <= `FLAGS_RESET;
      s_q.alarm_lo   <= `FLAGS_RESET;
      s_q.warn_hi    <= `FLAGS_RESET;
      s_q.warn_lo    <= `FLAGS_RESET;
      s_q.rdata      <= `RDATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // outputs
  assign reg_rdata_q      = s_q.rdata;
  assign reg_rvalid_q     = s_q.rvalid;
  assign tx_disable_q     = s_q.tx_disable;
  assign data_not_ready_q = s_q.not_ready;

endmodule

// [verif/diag_flags_asserts.sv]
// checker for the status and flag register port
`timescale 1ns/1ps
module diag_flags_chk (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       reg_rvalid_q,
  // pins and readiness
  input wire logic       rx_signal_lost,
  input wire logic       tx_disable_pin,
  input wire logic       tx_disable_q,
  input wire logic       mon_valid,
  input wire logic       data_not_ready_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // ==========================================================================
  // sequences
  sequence s_soft_wr;
    reg_wr && reg_addr == 8'h6e;
  endsequence
  sequence s_valid_up;
    $rose(mon_valid);
  endsequence
  sequence s_rsv_rd;
    reg_rd && (reg_addr == 8'h71 || reg_addr == 8'h75);
  endsequence
  // ==========================================================================
  // checks
  chk_rd_answer: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read without answer");
  chk_no_stray_rv: assert property (!reg_rd |=> !reg_rvalid_q)
    else $error("answer without read");
  chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without read");
  chk_soft_txdis: assert property (s_soft_wr |=> tx_disable_q == ($past(reg_wdata[6]) || $past(tx_disable_pin)))
    else $error("soft disable write not applied");
  chk_pin_txdis: assert property (tx_disable_pin |=> tx_disable_q)
    else $error("disable pin not followed");
  chk_not_ready: assert property (!mon_valid |=> data_not_ready_q)
    else $error("ready while values invalid");
  chk_ready_bound: assert property (s_valid_up |-> ##[0:201] (!data_not_ready_q || !mon_valid))
    else $error("ready too late");
  chk_los_bit: assert property ((reg_rd && reg_addr == 8'h6e && $stable(rx_signal_lost) && $past(reset_n))
    |=> reg_rdata_q[1] == $past(rx_signal_lost))
    else $error("loss bit wrong");
  chk_rsv_zero: assert property (s_rsv_rd |=> reg_rdata_q[5:0] == 6'h00)
    else $error("reserved bits set");
endmodule

bind diag_status_alarm_flags diag_flags_chk chk (
  .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .rx_signal_lost(rx_signal_lost), .tx_disable_pin(tx_disable_pin), .tx_disable_q(tx_disable_q),
  .mon_valid(mon_valid), .data_not_ready_q(data_not_ready_q)
);

// [verif/host_model.sv]
// host side model: byte reads and writes on the register port
`timescale 1ns/1ps
module host_model (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_rd,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q,
  input  wire logic       reg_rvalid_q
);
  initial begin
    reg_addr  = 8'h00;
    reg_rd    = 1'b0;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rvalid_q ? reg_rdata_q : 8'hxx;
  endtask
endmodule

// [verif/diag_status_alarm_flags_test.sv]
// self-checking bench for the status and flag block
`timescale 1ns/1ps
module diag_status_alarm_flags_test;
  logic        sys_clk, reset_n, rx_signal_lost, tx_disable_pin, mon_valid;
  logic [15:0] mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr;
  wire  [7:0]  reg_addr, reg_wdata, reg_rdata_q;
  wire         reg_rd, reg_wr, reg_rvalid_q, tx_disable_q, data_not_ready_q;
  logic [7:0]  d;
  logic [31:0] e;
  int          error_cnt, cmp_count;
  // temp, vcc, bias, txpwr, rxpwr, then flags 0x70 0x71 0x74 0x75
  logic [111:0] rows [6] = '{
    {80'h1900_80e8_4e20_0100_0100, 32'h0000_0000},
    {80'h5600_8caa_ea61_031b_031b, 32'haa80_aa80},
    {80'hd700_7526_1387_0031_0004, 32'h5540_5540},
    {80'h5100_88c2_d6d9_0278_0278, 32'h0000_aa80},
    {80'hdc00_790e_1d4b_003e_0005, 32'h0000_5540},
    {80'h5500_8ca0_ea60_031a_031a, 32'h0000_aa80}};

  host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q));
  diag_status_alarm_flags uut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_rvalid_q(reg_rvalid_q), .rx_signal_lost(rx_signal_lost), .tx_disable_pin(tx_disable_pin),
    .tx_disable_q(tx_disable_q), .mon_valid(mon_valid), .mon_temp(mon_temp), .mon_vcc(mon_vcc),
    .mon_bias(mon_bias), .mon_txpwr(mon_txpwr), .mon_rxpwr(mon_rxpwr),
    .data_not_ready_q(data_not_ready_q));

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // whole run is near 1700 cycles
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end

  initial begin
    {reset_n, rx_signal_lost, tx_disable_pin, mon_valid} = 4'h0;
    {mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr} = rows[0][111:32];
    error_cnt = 0;
    cmp_count = 0;
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    check({7'h00, data_not_ready_q}, 8'h01);
    check({7'h00, tx_disable_q}, 8'h00);
    @(posedge sys_clk);
    mon_valid <= 1'b1;
    repeat (202) @(posedge sys_clk);
    host.rd(8'h6e, d);
    check(d, 8'h00);
    check({7'h00, data_not_ready_q}, 8'h00);
    // ========================================================================
    // flag rows: refresh every 200 cycles, limits strict
    foreach (rows[i]) begin
      @(posedge sys_clk);
      {mon_temp, mon_vcc, mon_bias, mon_txpwr, mon_rxpwr} <= rows[i][111:32];
      e = rows[i][31:0];
      repeat (201) @(posedge sys_clk);
      host.rd(8'h70, d);
      check(d, e[31:24]);
      host.rd(8'h71, d);
      check(d, e[23:16]);
      host.rd(8'h74, d);
      check(d, e[15:8]);
      host.rd(8'h75, d);
      check(d, e[7:0]);
    end
    // ========================================================================
    // refused writes, unmapped read, status byte
    host.wr(8'h70, 8'hff);
    host.rd(8'h70, d);
    check(d, 8'h00);
    host.rd(8'h72, d);
    check(d, 8'h00);
    @(posedge sys_clk);
    rx_signal_lost <= 1'b1;
    host.wr(8'h6e, 8'h40);
    host.rd(8'h6e, d);
    check(d, 8'hc2);
    check({7'h00, tx_disable_q}, 8'h01);
    host.wr(8'h6e, 8'hbf);
    @(posedge sys_clk);
    tx_disable_pin <= 1'b1;
    host.rd(8'h6e, d);
    check(d, 8'h82);
    check({7'h00, tx_disable_q}, 8'h01);
    @(posedge sys_clk);
    tx_disable_pin <= 1'b0;
    rx_signal_lost <= 1'b0;
    repeat (2) @(posedge sys_clk);
    host.rd(8'h6e, d);
    check(d, 8'h00);
    check({7'h00, tx_disable_q}, 8'h00);
    // values lost: flags clear, not ready again
    @(posedge sys_clk);
    mon_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    host.rd(8'h74, d);
    check(d, 8'h00);
    host.rd(8'h6e, d);
    check(d, 8'h01);
    // ========================================================================
    // reset in mid-run: soft disable set, values valid while reset is held
    host.wr(8'h6e, 8'h40);
    @(posedge sys_clk);
    mon_valid <= 1'b1;
    reset_n   <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    #1;
    check({7'h00, tx_disable_q}, 8'h00);
    check({7'h00, data_not_ready_q}, 8'h01);
    check(reg_rdata_q, 8'h00);
    host.rd(8'h6e, d);
    check(d, 8'h01);
    // divider restarts at release, so ready comes one cycle after the first refresh tick
    repeat (200) @(posedge sys_clk);
    #1;
    check({7'h00, data_not_ready_q}, 8'h00);
    end_of_test();
  end
endmodule
